// ---- src/brsd_pkg.sv ----
package brsd_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Space geometry
  localparam int SPACE_BYTES = 512;                // Both banks together
  localparam int BANK_BYTES = 256;                 // One bank, low eight address bits
  localparam int CFG_COUNT = 12;                   // Bank 1 port configuration bytes
  localparam int MIXED_COUNT = 9;                  // Registers with per-bit access
  localparam int IRQ_COUNT = 8;                    // Pending sources behind the vector

  ////////////////////////////////////////////////////////////////////////////////
  // Offsets with side effects or special decode
  localparam logic [7:0] OFF_FLAG = 8'hf7;         // Processor flag, seen in both banks
  localparam logic [7:0] OFF_IRQ_CLEAR0 = 8'hda;   // Pending view, write 0 clears
  localparam logic [7:0] OFF_IRQ_MASK0 = 8'he0;    // Gates sources onto the vector
  localparam logic [7:0] OFF_IRQ_VECTOR = 8'he2;   // Read reports and clears
  localparam logic [7:0] OFF_WDT_RESTART = 8'he3;  // Write only, strobes restart
  localparam logic [7:0] OFF_CFG_LAST = 8'h0b;     // Last mapped bank 1 byte

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions and reset values
  localparam int BANK_BIT = 4;                     // Bank select bit in the flag
  localparam int STATUS_BIT = 7;                   // Hardware status bit of mixed registers
  localparam logic [7:0] MIXED_WMASK = 8'h7f;      // Software owns bits 6..0 of mixed registers
  localparam logic [7:0] FULL_MASK = 8'hff;        // Every bit writable
  localparam logic [7:0] FLAG_RESET = 8'h00;       // Flag after reset, bank 0
  localparam logic [7:0] REG_RESET = 8'h00;        // Every stored register after reset

  ////////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {
    LOP_AND = 3'b001,
    LOP_OR = 3'b010,
    LOP_XOR = 3'b100
  } brsd_lop_type;

  typedef struct packed {
    logic rd;                                      // One-cycle read strobe
    logic wr;                                      // One-cycle plain write strobe
    logic lop;                                     // One-cycle logical modify strobe
    brsd_lop_type lop_kind;                        // Operation of a logical modify
    logic [7:0] addr;                              // Offset within the bank
    logic [7:0] wdata;                             // Write data or modify operand
  } brsd_req_type;

  typedef struct packed {
    logic mapped;                                  // Offset is assigned
    logic rd_ok;                                   // Reads return contents
    logic store;                                   // Value lives in the register array
    logic mixed;                                   // Bit 7 is hardware status
    logic [7:0] wmask;                             // Writable bits
  } brsd_attr_type;

  ////////////////////////////////////////////////////////////////////////////////
  // Bank 0 access table
  function automatic brsd_attr_type bank0_attr(input logic [7:0] off);
    brsd_attr_type a;
    a = '{mapped: 1'b0, rd_ok: 1'b0, store: 1'b0, mixed: 1'b0, wmask: 8'h00};
    case (off)
      8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
      8'h08, 8'h09, 8'h0a, 8'h0b, 8'h22, 8'h26, 8'h2a, 8'h61,
      8'h62, 8'h66, 8'h84, 8'hd0, 8'hd1, 8'hd3, 8'hd4, 8'hd5,
      8'hd6, 8'hd8, 8'hdb, 8'hdd, 8'hde, 8'he0, 8'he1, 8'he6,
      8'he7: a = '{mapped: 1'b1, rd_ok: 1'b1, store: 1'b1, mixed: 1'b0, wmask: FULL_MASK};
      8'h20, 8'h23, 8'h24, 8'h27, 8'h28, 8'h64, 8'h69, 8'hd7,
      8'hd9: a = '{mapped: 1'b1, rd_ok: 1'b1, store: 1'b1, mixed: 1'b1, wmask: MIXED_WMASK};
      8'h21, 8'h25, 8'h29: a = '{mapped: 1'b1, rd_ok: 1'b0, store: 1'b1, mixed: 1'b0, wmask: FULL_MASK};
      OFF_IRQ_CLEAR0, OFF_IRQ_VECTOR: a = '{mapped: 1'b1, rd_ok: 1'b1, store: 1'b0, mixed: 1'b0, wmask: 8'h00};
      OFF_WDT_RESTART: a = '{mapped: 1'b1, rd_ok: 1'b0, store: 1'b0, mixed: 1'b0, wmask: 8'h00};
      default: a = '{mapped: 1'b0, rd_ok: 1'b0, store: 1'b0, mixed: 1'b0, wmask: 8'h00};
    endcase
    return a;
  endfunction : bank0_attr

  // Which hardware status input feeds bit 7 of a mixed register
  function automatic logic [3:0] mixed_index(input logic [7:0] off);
    logic [3:0] i;
    i = 4'h0;
    case (off)
      8'h20: i = 4'h0;
      8'h23: i = 4'h1;
      8'h24: i = 4'h2;
      8'h27: i = 4'h3;
      8'h28: i = 4'h4;
      8'h64: i = 4'h5;
      8'h69: i = 4'h6;
      8'hd7: i = 4'h7;
      8'hd9: i = 4'h8;
      default: i = 4'h0;
    endcase
    return i;
  endfunction : mixed_index

endpackage : brsd_pkg

// ---- src/brsd_top.sv ----
// How it works
// [R1] Byte-wide I/O space of 512 locations total
// [R2] Two banks share offsets: user and configuration
// [R3] Flag bank bit set sends accesses to bank 1
// [R4] Software never touches unassigned offsets
// [R5] Reads return current contents of readable bits
// [R6] Writes store; write-only locations read zero
// [R7] Flag changes only through logical modify operations
// [R8] Vector read clears the pending source it reports
// [R9] Access type applied bit by bit where mixed
// [R10] Flag bank bit clear selects bank 0
// [R11] Reserved offsets read zero, ignore writes
`timescale 1ns/1ps
module brsd_top (
  input wire logic clk,
  input wire logic rst,
  input wire brsd_pkg::brsd_req_type io_req,
  input wire logic [8:0] hw_status,
  input wire logic [7:0] irq_event,
  output logic [7:0] io_rdata_r,
  output logic io_rvalid_r,
  output logic [7:0] flag_r,
  output logic wdt_restart_r,
  output logic [255:0][7:0] bank0_regs_r,
  output logic [11:0][7:0] bank1_regs_r
);

  ////////////////////////////////////////////////////////////////////////////////
  // Decode of the current access

  logic bank1_sel;                       // High when the flag points at bank 1
  logic flag_hit;                        // Flag is reachable from either bank
  logic cfg_hit;                         // Mapped bank 1 configuration byte
  brsd_pkg::brsd_attr_type attr;         // Bank 0 access attributes
  logic [7:0] irq_pending_r;             // Sticky pending sources
  logic [7:0] irq_vector;                // Encoded highest priority pending source
  logic [7:0] irq_top;                   // One-hot of the reported source
  logic [7:0] rd_value;                  // Value a read would return now
  logic [7:0] flag_nxt;                  // Flag after a logical modify

  // Bank choice follows the flag; the space is 2 x 256, addressed by 8 bits
  // Nothing latches the bank, so a flag change applies from the next request
  assign bank1_sel = flag_r[brsd_pkg::BANK_BIT]; // [R3] [R10] [R1]
  assign flag_hit = (io_req.addr == brsd_pkg::OFF_FLAG);
  assign cfg_hit = bank1_sel && (io_req.addr <= brsd_pkg::OFF_CFG_LAST); // [R2]
  assign attr = brsd_pkg::bank0_attr(io_req.addr);

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt vector encode

  // Lowest numbered enabled source wins; vector 0 means no enabled source pending
  // Only the first mask byte gates the vector; the other masks are plain storage
  always_comb begin
    irq_vector = 8'h00;
    irq_top = 8'h00;
    for (int i = brsd_pkg::IRQ_COUNT - 1; i >= 0; i--) begin
      if (irq_pending_r[i] && bank0_regs_r[brsd_pkg::OFF_IRQ_MASK0][i]) begin
        irq_vector = 8'(i + 1);
        irq_top = 8'(1 << i);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read value mux

  // Reserved and write-only locations give zero so a stray read is harmless
  // Zero rather than old contents, so software never sees stale state there
  always_comb begin
    rd_value = 8'h00;
    if (flag_hit) begin
      // Flag is readable from both banks
      rd_value = flag_r; // [R5]
    end else if (bank1_sel) begin
      // Bank 1 holds only the port configuration bytes
      if (cfg_hit) begin
        rd_value = bank1_regs_r[io_req.addr[3:0]]; // [R2] [R5]
      end else begin
        rd_value = 8'h00; // [R11]
      end
    end else if (!attr.mapped || !attr.rd_ok) begin
      // Unassigned offset or write-only register
      rd_value = 8'h00; // [R11] [R6]
    end else if (io_req.addr == brsd_pkg::OFF_IRQ_CLEAR0) begin
      // Pending view
      rd_value = irq_pending_r; // [R5]
    end else if (io_req.addr == brsd_pkg::OFF_IRQ_VECTOR) begin
      // Encoded vector
      rd_value = irq_vector; // [R5]
    end else if (attr.mixed) begin
      // Software bits from storage, status bit straight from hardware
      rd_value = (bank0_regs_r[io_req.addr] & attr.wmask) |
                 {hw_status[brsd_pkg::mixed_index(io_req.addr)], 7'h00}; // [R9]
    end else begin
      // Plain stored register
      rd_value = bank0_regs_r[io_req.addr]; // [R5]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read port

  // Data lands one cycle after the strobe and holds until the next read
  // Valid stands one cycle only; the caller takes the data in that cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      io_rdata_r <= 8'h00;
      io_rvalid_r <= 1'b0;
    end else begin
      io_rvalid_r <= io_req.rd; // [R5]
      if (io_req.rd) begin
        io_rdata_r <= rd_value; // [R5]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Processor flag

  // Logical modify of the flag; plain writes have no path into it
  // Keeping plain stores out stops a stray write from flipping banks
  always_comb begin
    case (io_req.lop_kind)
      brsd_pkg::LOP_AND: flag_nxt = flag_r & io_req.wdata;
      brsd_pkg::LOP_OR: flag_nxt = flag_r | io_req.wdata;
      brsd_pkg::LOP_XOR: flag_nxt = flag_r ^ io_req.wdata;
      default: flag_nxt = flag_r;
    endcase
  end

  // Only a logical modify at the flag offset changes it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_r <= brsd_pkg::FLAG_RESET;
    end else if (io_req.lop && flag_hit) begin
      flag_r <= flag_nxt; // [R7]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bank 0 storage

  // Masked write keeps the read-only bits of mixed registers intact
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bank0_regs_r <= '0;
    end else if (io_req.wr && !bank1_sel && attr.store) begin
      // Reserved offsets have store clear, so they fall through untouched
      bank0_regs_r[io_req.addr] <= (bank0_regs_r[io_req.addr] & ~attr.wmask) |
                                   (io_req.wdata & attr.wmask); // [R6] [R9] [R10] [R11]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bank 1 storage

  // Configuration bytes share the low offsets of bank 0
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bank1_regs_r <= '0;
    end else if (io_req.wr && cfg_hit) begin
      bank1_regs_r[io_req.addr[3:0]] <= io_req.wdata; // [R2] [R3]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pending sources

  // New events are ORed in last, so an event never loses to a clear
  // Trade-off: software may post a source by writing 1, handy for self test
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_pending_r <= 8'h00;
    end else begin
      if (io_req.wr && !bank1_sel && io_req.addr == brsd_pkg::OFF_IRQ_CLEAR0) begin
        // Writing 0 clears a bit, writing 1 posts it from software
        irq_pending_r <= io_req.wdata | irq_event;
      end else if (io_req.rd && !bank1_sel && io_req.addr == brsd_pkg::OFF_IRQ_VECTOR) begin
        // Reading the vector acknowledges the source it names
        irq_pending_r <= (irq_pending_r & ~irq_top) | irq_event; // [R8]
      end else begin
        irq_pending_r <= irq_pending_r | irq_event;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog restart strobe

  // Restart location stores nothing; a write only pulses the strobe
  // A write made while bank 1 is selected never reaches this strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wdt_restart_r <= 1'b0;
    end else begin
      wdt_restart_r <= io_req.wr && !bank1_sel && (io_req.addr == brsd_pkg::OFF_WDT_RESTART); // [R6]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  // Captured request, read only by the checks below
  logic [7:0] chk_addr_r;
  logic [7:0] chk_data_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chk_addr_r <= 8'h00;
      chk_data_r <= 8'h00;
    end else begin
      chk_addr_r <= io_req.addr;
      chk_data_r <= io_req.wdata;
    end
  end

  // Requests that may lower a pending bit, named for the checks
  logic clr_wr_hit;
  logic vec_rd_hit;
  assign clr_wr_hit = io_req.wr && !bank1_sel && (io_req.addr == brsd_pkg::OFF_IRQ_CLEAR0);
  assign vec_rd_hit = io_req.rd && !bank1_sel && (io_req.addr == brsd_pkg::OFF_IRQ_VECTOR);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Limits of these checks: the processor raises one strobe per request,
  // so no check covers a read and a write in the same cycle.
  // Read data is compared with the value stored one cycle earlier,
  // which is what a read in the same cycle as a write must return.
  // The status bit of the mixed registers is judged by the bench only,
  // since its source index lives in the shared decode table.

  // Unmapped bank 0 offsets read zero
  reserved_read_zero_a: assert property ( // [R11]
    io_req.rd && !bank1_sel && !flag_hit && !attr.mapped |=> io_rdata_r == 8'h00 && io_rvalid_r)
    else $error("reserved offset read gave nonzero data");

  // Unmapped bank 0 offsets ignore plain writes
  reserved_write_keep_a: assert property ( // [R11]
    io_req.wr && !io_req.lop && !bank1_sel && !attr.mapped |=> $stable(bank0_regs_r) && $stable(flag_r))
    else $error("reserved offset write changed state");

  // Bank 1 writes land in the configuration bytes only
  bank1_write_route_a: assert property ( // [R3]
    io_req.wr && cfg_hit |=> bank1_regs_r[chk_addr_r[3:0]] == chk_data_r && $stable(bank0_regs_r))
    else $error("bank 1 write misrouted");

  // Plain bank 0 writes store the whole byte
  bank0_write_store_a: assert property ( // [R10]
    io_req.wr && !bank1_sel && attr.store && !attr.mixed |=> bank0_regs_r[chk_addr_r] == chk_data_r)
    else $error("bank 0 write not stored");

  // Status bit of a mixed register is never stored
  mixed_status_keep_a: assert property ( // [R9]
    io_req.wr && !bank1_sel && attr.mixed |=> bank0_regs_r[chk_addr_r][brsd_pkg::STATUS_BIT] == 1'b0)
    else $error("status bit of a mixed register was written");

  // Plain writes never reach the flag
  flag_plain_write_a: assert property ( // [R7]
    io_req.wr && !io_req.lop && flag_hit |=> $stable(flag_r))
    else $error("plain write changed the flag");

  // Logical or on the flag
  flag_logic_or_a: assert property ( // [R7]
    io_req.lop && flag_hit && io_req.lop_kind == brsd_pkg::LOP_OR |=> flag_r == ($past(flag_r) | chk_data_r))
    else $error("logical or on flag wrong");

  // Vector read clears exactly one source
  vector_read_clear_a: assert property ( // [R8]
    io_req.rd && !bank1_sel && io_req.addr == brsd_pkg::OFF_IRQ_VECTOR && irq_vector != 8'h00 &&
    irq_event == 8'h00 |=> $countones(irq_pending_r) == $countones($past(irq_pending_r)) - 1)
    else $error("vector read did not clear its source");

  // An event on source 0 in the cycle of a clear still posts
  event_beats_clear_a: assert property ( // [R8]
    irq_event[0] |=> irq_pending_r[0])
    else $error("event lost against a clear");

  // Restart write pulses the strobe and stores nothing
  wdt_strobe_a: assert property ( // [R6]
    io_req.wr && !bank1_sel && io_req.addr == brsd_pkg::OFF_WDT_RESTART |=> wdt_restart_r ##0 $stable(bank0_regs_r))
    else $error("restart write did not strobe");

  // Flag reads back one cycle after the strobe
  read_latency_a: assert property ( // [R5]
    io_req.rd && flag_hit |=> io_rvalid_r && io_rdata_r == $past(flag_r))
    else $error("flag read wrong or late");

  // Bank 1 reads return the configuration byte
  bank1_read_route_a: assert property ( // [R3]
    io_req.rd && cfg_hit |=> io_rdata_r == $past(bank1_regs_r[io_req.addr[3:0]]))
    else $error("bank 1 read returned the wrong byte");

  // Unmapped bank 1 offsets read zero
  bank1_reserved_read_a: assert property ( // [R11]
    io_req.rd && bank1_sel && !cfg_hit && !flag_hit |=> io_rdata_r == 8'h00)
    else $error("reserved bank 1 offset read gave nonzero data");

  // Plain bank 0 registers read back what they hold
  bank0_read_plain_a: assert property ( // [R5]
    io_req.rd && !bank1_sel && attr.store && attr.rd_ok && !attr.mixed |=>
    io_rdata_r == $past(bank0_regs_r[io_req.addr]))
    else $error("bank 0 read returned the wrong byte");

  // Write-only locations read zero
  write_only_read_a: assert property ( // [R6]
    io_req.rd && !bank1_sel && attr.mapped && !attr.rd_ok |=> io_rdata_r == 8'h00)
    else $error("write-only location read gave nonzero data");

  // Software bits of a mixed register read back as stored
  mixed_read_low_a: assert property ( // [R9]
    io_req.rd && !bank1_sel && attr.mixed |=>
    (io_rdata_r & brsd_pkg::MIXED_WMASK) == ($past(bank0_regs_r[io_req.addr]) & brsd_pkg::MIXED_WMASK))
    else $error("software bits of a mixed register read wrong");

  // A logical modify away from the flag changes nothing
  lop_other_keep_a: assert property ( // [R7]
    io_req.lop && !io_req.wr && !flag_hit |=>
    $stable(flag_r) && $stable(bank0_regs_r) && $stable(bank1_regs_r))
    else $error("logical modify away from the flag changed state");

  // Logical and on the flag
  flag_logic_and_a: assert property ( // [R7]
    io_req.lop && flag_hit && io_req.lop_kind == brsd_pkg::LOP_AND |=> flag_r == ($past(flag_r) & chk_data_r))
    else $error("logical and on flag wrong");

  // Logical exclusive or on the flag
  flag_logic_xor_a: assert property ( // [R7]
    io_req.lop && flag_hit && io_req.lop_kind == brsd_pkg::LOP_XOR |=> flag_r == ($past(flag_r) ^ chk_data_r))
    else $error("logical xor on flag wrong");

  // Vector reads zero when no enabled source is pending
  vector_idle_a: assert property ( // [R8]
    vec_rd_hit && (irq_pending_r & bank0_regs_r[brsd_pkg::OFF_IRQ_MASK0]) == 8'h00 |=> io_rdata_r == 8'h00)
    else $error("vector read nonzero with nothing pending");

  // Pending write takes the data, events still get in
  pending_write_a: assert property ( // [R8]
    clr_wr_hit |=> irq_pending_r == (chk_data_r | $past(irq_event)))
    else $error("pending write stored the wrong value");

  // Every event posts its source
  event_posts_all_a: assert property ( // [R8]
    irq_event != 8'h00 |=> (irq_pending_r & $past(irq_event)) == $past(irq_event))
    else $error("event did not post its source");

  // Pending bits drop only by a clear write or a vector read
  pending_hold_a: assert property ( // [R8]
    !clr_wr_hit && !vec_rd_hit |=> (irq_pending_r & $past(irq_pending_r)) == $past(irq_pending_r))
    else $error("pending bit dropped without a clear");

  // Restart strobe only after a restart write
  wdt_quiet_a: assert property ( // [R6]
    !(io_req.wr && !bank1_sel && io_req.addr == brsd_pkg::OFF_WDT_RESTART) |=> !wdt_restart_r)
    else $error("restart strobe without a restart write");

  // Read valid only after a read strobe
  rvalid_idle_a: assert property ( // [R5]
    !io_req.rd |=> !io_rvalid_r)
    else $error("read valid without a read");

  // Read data holds between reads
  rdata_hold_a: assert property ( // [R5]
    !io_req.rd |=> $stable(io_rdata_r))
    else $error("read data moved without a read");

  // Writes in bank 1 mode never reach bank 0
  bank1_mode_write_a: assert property ( // [R3]
    io_req.wr && bank1_sel |=> $stable(bank0_regs_r) && !wdt_restart_r)
    else $error("bank 1 write reached bank 0");

  // Unmapped bank 1 offsets ignore writes
  bank1_reserved_write_a: assert property ( // [R11]
    io_req.wr && bank1_sel && !cfg_hit |=> $stable(bank1_regs_r))
    else $error("reserved bank 1 write changed state");

  // Flag moves only under a logical modify at its offset
  flag_hold_a: assert property ( // [R7]
    !(io_req.lop && flag_hit) |=> $stable(flag_r))
    else $error("flag changed without a logical modify");

endmodule : brsd_top

// ---- sim/brsd_cpu_model.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Processor side of the I/O space: one request at a time, one-cycle strobes
module brsd_cpu_model (
  input wire logic clk,
  output brsd_pkg::brsd_req_type io_req,
  input wire logic [7:0] io_rdata_r,
  input wire logic io_rvalid_r
);
  // Bus idle from time zero
  initial begin
    io_req = '0;
  end
  // Only offsets the caller names are touched; reserved ones only when a scenario asks
  // Released lines show inverted data so a stale value never looks valid
  task automatic issue(input logic [2:0] s, input brsd_pkg::brsd_lop_type k, input logic [7:0] a,
                       input logic [7:0] d);
    @(posedge clk);
    io_req <= '{rd: s[2], wr: s[1], lop: s[0], lop_kind: k, addr: a, wdata: d};
    @(posedge clk);
    io_req <= '{rd: 1'b0, wr: 1'b0, lop: 1'b0, lop_kind: k, addr: ~a, wdata: ~d};
    #1;
  endtask : issue
  // Read: answer lands at the taking edge and is sampled just after it
  task automatic rd_byte(input logic [7:0] a, output logic [7:0] d, output logic v);
    issue(3'b100, brsd_pkg::LOP_OR, a, 8'h00);
    d = io_rdata_r;
    v = io_rvalid_r;
  endtask : rd_byte
  // Plain write
  task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
    issue(3'b010, brsd_pkg::LOP_OR, a, d);
  endtask : wr_byte
  // Logical modify, the only way to change the flag
  task automatic modify(input brsd_pkg::brsd_lop_type k, input logic [7:0] a, input logic [7:0] d);
    issue(3'b001, k, a, d);
  endtask : modify
endmodule : brsd_cpu_model

// ---- sim/banked_register_space_decode_bench.sv ----
`timescale 1ns/1ps
module banked_register_space_decode_bench;
  logic clk;
  logic rst;
  logic [8:0] hw_status;
  logic [7:0] irq_event;
  brsd_pkg::brsd_req_type io_req;
  logic [7:0] io_rdata_r;
  logic io_rvalid_r;
  logic [7:0] flag_r;
  logic wdt_restart_r;
  logic [255:0][7:0] bank0_regs_r;
  logic [11:0][7:0] bank1_regs_r;
  int err_total;
  int cmp_count;

  ////////////////////////////////////////////////////////////////////////////////
  brsd_top dut (.clk(clk), .rst(rst), .io_req(io_req), .hw_status(hw_status), .irq_event(irq_event),
    .io_rdata_r(io_rdata_r), .io_rvalid_r(io_rvalid_r), .flag_r(flag_r), .wdt_restart_r(wdt_restart_r),
    .bank0_regs_r(bank0_regs_r), .bank1_regs_r(bank1_regs_r));
  brsd_cpu_model cpu (.clk(clk), .io_req(io_req), .io_rdata_r(io_rdata_r), .io_rvalid_r(io_rvalid_r));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: expected %h, got %h", $time, exp, got);
    end
  endtask : chk
  // Read with valid strobe checked in its one cycle
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    cpu.rd_byte(a, d, v);
    chk(8'h01, {7'h00, v});
    chk(exp, d);
  endtask : rd_chk

  ////////////////////////////////////////////////////////////////////////////////
  // Plain registers across the map, value tied to offset
  task automatic test_rw();
    logic [7:0] offs [0:6] = '{8'h00, 8'h0b, 8'h22, 8'h61, 8'h84, 8'hd0, 8'he7};
    chk(8'h00, flag_r);
    foreach (offs[i]) begin
      cpu.wr_byte(offs[i], offs[i] ^ 8'h5a);
      chk(offs[i] ^ 8'h5a, bank0_regs_r[offs[i]]);
      rd_chk(offs[i], offs[i] ^ 8'h5a);
    end
  endtask : test_rw
  // Write-only places store but read zero; restart strobes once
  task automatic test_write_only();
    cpu.wr_byte(8'h21, 8'ha5);
    chk(8'ha5, bank0_regs_r[8'h21]);
    rd_chk(8'h21, 8'h00);
    cpu.wr_byte(brsd_pkg::OFF_WDT_RESTART, 8'h77);
    chk(8'h01, {7'h00, wdt_restart_r});
    @(posedge clk);
    #1;
    chk(8'h00, {7'h00, wdt_restart_r});
  endtask : test_write_only
  // Status bit comes from hardware, low bits from software
  task automatic test_mixed();
    @(posedge clk) hw_status <= 9'h001;
    cpu.wr_byte(8'h20, 8'hff);
    chk(8'h7f, bank0_regs_r[8'h20]);
    rd_chk(8'h20, 8'hff);
    @(posedge clk) hw_status <= 9'h100;
    rd_chk(8'h20, 8'h7f);
    rd_chk(8'hd9, 8'h80);
  endtask : test_mixed
  // Reserved offsets hold nothing
  task automatic test_reserved();
    cpu.wr_byte(8'h0c, 8'h5a);
    chk(8'h00, bank0_regs_r[8'h0c]);
    rd_chk(8'h0c, 8'h00);
  endtask : test_reserved
  // Flag reachable only by modify; bank bit steers every access except those at the flag offset
  task automatic test_banks();
    cpu.wr_byte(brsd_pkg::OFF_FLAG, 8'h10);
    chk(8'h00, flag_r);
    cpu.modify(brsd_pkg::LOP_OR, 8'h00, 8'hff);
    chk(8'h5a, bank0_regs_r[8'h00]);
    cpu.modify(brsd_pkg::LOP_OR, brsd_pkg::OFF_FLAG, 8'h10);
    chk(8'h10, flag_r);
    rd_chk(brsd_pkg::OFF_FLAG, 8'h10);
    cpu.wr_byte(8'h00, 8'ha5);
    chk(8'ha5, bank1_regs_r[0]);
    chk(8'h5a, bank0_regs_r[8'h00]);
    rd_chk(8'h00, 8'ha5);
    cpu.wr_byte(8'h0c, 8'h66);
    rd_chk(8'h0c, 8'h00);
    cpu.modify(brsd_pkg::LOP_XOR, brsd_pkg::OFF_FLAG, 8'h10);
    chk(8'h00, flag_r);
    rd_chk(8'h00, 8'h5a);
    cpu.modify(brsd_pkg::LOP_XOR, brsd_pkg::OFF_FLAG, 8'h10);
    cpu.modify(brsd_pkg::LOP_AND, brsd_pkg::OFF_FLAG, 8'hef);
    chk(8'h00, flag_r);
  endtask : test_banks
  // Vector read clears only the source it reports; masked source stays
  task automatic test_irq();
    cpu.wr_byte(brsd_pkg::OFF_IRQ_MASK0, 8'h04);
    @(posedge clk) irq_event <= 8'h06;
    @(posedge clk) irq_event <= 8'h00;
    rd_chk(brsd_pkg::OFF_IRQ_CLEAR0, 8'h06);
    rd_chk(brsd_pkg::OFF_IRQ_VECTOR, 8'h03);
    rd_chk(brsd_pkg::OFF_IRQ_CLEAR0, 8'h02);
    rd_chk(brsd_pkg::OFF_IRQ_VECTOR, 8'h00);
    @(posedge clk) irq_event <= 8'h01;
    cpu.wr_byte(brsd_pkg::OFF_IRQ_CLEAR0, 8'h00);
    @(posedge clk) irq_event <= 8'h00;
    rd_chk(brsd_pkg::OFF_IRQ_CLEAR0, 8'h01);
    cpu.wr_byte(brsd_pkg::OFF_IRQ_CLEAR0, 8'h00);
    rd_chk(brsd_pkg::OFF_IRQ_CLEAR0, 8'h00);
  endtask : test_irq

  ////////////////////////////////////////////////////////////////////////////////
  // Counts, verdict, end of run
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  // Main sequence
  initial begin
    rst = 1'b1;
    hw_status = '0;
    irq_event = '0;
    err_total = 0;
    cmp_count = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    test_rw();
    test_write_only();
    test_mixed();
    test_reserved();
    test_banks();
    test_irq();
    summarize();
  end
  // Hang guard, far beyond the normal run length
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    $display("mismatch at %0t: expected %h, got %h", $time, 8'h00, 8'hff);
    summarize();
  end
endmodule : banked_register_space_decode_bench
